// >>> inc/rstctl_pkg.sv
// Package with constants and types for the reset state controller
package rstctl_pkg;
    localparam int RSTCTL_NSRC = 4;                 // Number of reset sources
    localparam int RSTCTL_SRC_POR = 0;              // Power-on source index
    localparam int RSTCTL_SRC_VDDMON = 1;           // Supply monitor source index
    localparam int RSTCTL_SRC_PIN = 2;              // Reset pin source index
    localparam int RSTCTL_SRC_SOFT = 3;             // Logic sources (watchdog, software)
    localparam logic [7:0] RSTCTL_PORT_RST = 8'hff; // Port latch reset value
    localparam logic [15:0] RSTCTL_PC_RST = 16'h0000; // First fetch address
    localparam logic [3:0] RSTCTL_WDT_DIV = 4'hb;   // Divide by 12, terminal count
    localparam logic [3:0] RSTCTL_WDT_ZERO = 4'h0;  // Divider restart value
    localparam logic [1:0] RSTCTL_CLKSEL_INT = 2'h0; // Internal oscillator select
    localparam int RSTCTL_CLK_HZ = 100000000;       // System clock rate
    localparam int RSTCTL_HOLD_NS = 50;             // Least hold of reset after release
    localparam int RSTCTL_HOLD_CYC = (RSTCTL_HOLD_NS * (RSTCTL_CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] RSTCTL_HOLD_LAST = 8'(RSTCTL_HOLD_CYC - 1); // Hold count end
    localparam logic [7:0] RSTCTL_CNT_ZERO = 8'h00; // Counter clear value

    // Controller states
    typedef enum logic [1:0] {
        RSTCTL_ST_RESET = 2'b00,  // Reset held
        RSTCTL_ST_HOLD = 2'b01,   // Sources gone, counting hold
        RSTCTL_ST_WCLK = 2'b10,   // Waiting for stable clock
        RSTCTL_ST_RUN = 2'b11     // Core running
    } rstctl_state_t;
endpackage

// >>> inc/rstctl_sync_if.sv
// Interface carrying the reset synchroniser signals
`timescale 1ns/10ps
interface rstctl_sync_if;
    logic async_rst;  // Combined asynchronous reset request
    logic sync_rst;   // Reset released in step with clk
    modport src (output async_rst, input sync_rst);
    modport sink (input async_rst, output sync_rst);
endinterface

// >>> core/rstctl_sync.sv
// Reset synchroniser: asynchronous assert, synchronous release
`timescale 1ns/10ps
module rstctl_sync
    import rstctl_pkg::*;
(
    input wire logic clk,
    rstctl_sync_if.sink sif
);
    logic stage1;  // First stage, read only by stage2
    logic stage2;  // Second stage

    // Asserts at once, releases after two edges
    always_ff @(posedge clk or posedge sif.async_rst) begin
        if (sif.async_rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
        end else begin
            stage1 <= 1'b0;
            stage2 <= stage1;
        end
    end

    assign sif.sync_rst = stage2;
endmodule

// >>> core/rstctl_top.sv
// Reset state controller: combines reset sources and sequences exit
//
// Contract
// - Core halted while reset state active
// - Registers load reset values on entry
// - Interrupts and timers disabled on entry
// - Data RAM kept; only stack pointer reinitialised
// - Port latches 0xFF, open-drain on reset
// - Weak pullups on during and after reset
// - Power-on or monitor reset drives pin low
// - Program counter cleared on exit
// - Internal oscillator selected on exit
// - Watchdog enabled, clocked sysclk divided 12
// - Execute from 0x0000 once clock stable
`timescale 1ns/10ps
module rstctl_top
    import rstctl_pkg::*;
(
    clk,
    rst,
    clk_en,
    por_req,
    vddmon_req,
    pin_rst_n,
    soft_req,
    clk_stable,
    core_run,
    sfr_init,
    irq_disable,
    timer_disable,
    ram_keep,
    sp_init,
    port_latch,
    port_open_drain,
    weak_pullup_en,
    rst_pin_out,
    rst_pin_oe,
    pc_value,
    pc_load,
    clk_sel,
    wdt_enable,
    wdt_tick
);
    input wire logic clk;               // System clock
    input wire logic rst;               // Synchronous reset, active high
    input wire logic clk_en;            // Clock enable
    input wire logic por_req;           // Power-on detector
    input wire logic vddmon_req;        // Supply monitor
    input wire logic pin_rst_n;         // Reset pin level, active low
    input wire logic soft_req;          // Watchdog, software, logic sources
    input wire logic clk_stable;        // Oscillator stable indication
    output logic core_run;              // Core may fetch and execute
    output logic sfr_init;              // Load register reset values
    output logic irq_disable;           // Interrupt sources disabled
    output logic timer_disable;         // Timers disabled
    output logic ram_keep;              // Data RAM write protected
    output logic sp_init;               // Stack pointer reinitialise
    output logic [7:0] port_latch;      // Port output latches
    output logic port_open_drain;       // Port open-drain mode
    output logic weak_pullup_en;        // Weak pullups enable
    output logic rst_pin_out;           // Reset pin output level
    output logic rst_pin_oe;            // Reset pin drive enable
    output logic [15:0] pc_value;       // Program counter start value
    output logic pc_load;               // Load pc_value into core
    output logic [1:0] clk_sel;         // System clock source select
    output logic wdt_enable;            // Watchdog enable
    output logic wdt_tick;              // Watchdog clock enable pulse

    ////////////////////////////////////////////////////////////////////////////
    // Source combining
    ////////////////////////////////////////////////////////////////////////////
    rstctl_sync_if sif();               // Synchroniser link
    logic [RSTCTL_NSRC-1:0] src;        // Raw source vector
    logic pin_s1, pin_s2;               // Reset pin synchroniser
    logic clk_s1, clk_s2;               // Clock-stable synchroniser
    logic pwr_s1, pwr_s2;               // Power source synchroniser

    assign src[RSTCTL_SRC_POR] = por_req;
    assign src[RSTCTL_SRC_VDDMON] = vddmon_req;
    assign src[RSTCTL_SRC_PIN] = ~pin_rst_n;
    assign src[RSTCTL_SRC_SOFT] = soft_req;
    assign sif.async_rst = |src;

    rstctl_sync u_sync (
        .clk(clk),
        .sif(sif)
    );

    // Pin-level synchronisers
    always_ff @(posedge clk) begin
        pin_s1 <= ~pin_rst_n;
        pin_s2 <= pin_s1;
        clk_s1 <= clk_stable;
        clk_s2 <= clk_s1;
        pwr_s1 <= por_req | vddmon_req;
        pwr_s2 <= pwr_s1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    ////////////////////////////////////////////////////////////////////////////
    rstctl_state_t state, next_state;   // Sequencer state
    logic [7:0] hold_cnt, next_hold_cnt; // Release hold counter
    logic pwr_flag, next_pwr_flag;      // Reset came from power source
    logic [3:0] div_cnt, next_div_cnt;  // Watchdog divider
    logic in_reset;                     // Reset state active
    logic enter;                        // Any request (forces reset)
    logic hold_done;                    // Hold count reached
    logic div_end;                      // Divider wrap

    assign enter = rst | sif.sync_rst;
    assign hold_done = (hold_cnt == RSTCTL_HOLD_LAST);
    assign div_end = (div_cnt == RSTCTL_WDT_DIV);
    assign in_reset = (state != RSTCTL_ST_RUN);

    // Next-state decode
    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_pwr_flag = pwr_flag | pwr_s2;          // Set wins
        case (state)
            RSTCTL_ST_RESET: begin
                next_hold_cnt = RSTCTL_CNT_ZERO;
                if (!enter) begin
                    next_state = RSTCTL_ST_HOLD;
                end
            end
            RSTCTL_ST_HOLD: begin
                next_hold_cnt = hold_cnt + 8'h01;
                if (hold_done) begin
                    next_state = RSTCTL_ST_WCLK;
                end
            end
            RSTCTL_ST_WCLK: begin
                if (clk_s2) begin
                    next_state = RSTCTL_ST_RUN;
                    next_pwr_flag = pwr_s2;         // Clear on exit, a new set wins
                end
            end
            RSTCTL_ST_RUN: begin
                next_pwr_flag = pwr_s2;
            end
            default: begin
                next_state = RSTCTL_ST_RESET;
            end
        endcase
        if (enter) begin
            next_state = RSTCTL_ST_RESET;
        end
    end

    assign next_div_cnt = (in_reset || div_end) ? RSTCTL_WDT_ZERO
                        : div_cnt + 4'h1;

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= RSTCTL_ST_RESET;
            hold_cnt <= RSTCTL_CNT_ZERO;
            pwr_flag <= 1'b0;
            div_cnt <= RSTCTL_WDT_ZERO;
        end else if (clk_en) begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            pwr_flag <= next_pwr_flag;
            div_cnt <= next_div_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////
    assign core_run = (state == RSTCTL_ST_RUN);
    assign sfr_init = in_reset;
    assign irq_disable = in_reset;
    assign timer_disable = in_reset;
    assign ram_keep = in_reset;
    assign sp_init = in_reset;
    assign port_latch = RSTCTL_PORT_RST;            // Latches held at 0xFF in reset and after it
    assign port_open_drain = in_reset;
    assign weak_pullup_en = 1'b1;
    assign rst_pin_out = 1'b0;                      // Pin only ever pulled low
    assign rst_pin_oe = in_reset & pwr_flag;
    assign pc_value = RSTCTL_PC_RST;
    assign pc_load = in_reset;
    assign clk_sel = RSTCTL_CLKSEL_INT;
    assign wdt_enable = core_run;
    assign wdt_tick = core_run & div_end & clk_en;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////
    a_halt_in_reset: assert property (@(posedge clk) disable iff (rst)
        enter |=> !core_run) else $error("core runs during reset");
    a_sfr_on_entry: assert property (@(posedge clk) disable iff (rst)
        !core_run |-> sfr_init) else $error("sfr init missing");
    a_irq_off: assert property (@(posedge clk) disable iff (rst)
        !core_run |-> irq_disable && timer_disable) else $error("irq or timer on");
    a_ram_keep: assert property (@(posedge clk) disable iff (rst)
        sp_init |-> ram_keep) else $error("ram unprotected");
    a_port_state: assert property (@(posedge clk) disable iff (rst)
        in_reset |-> port_latch == RSTCTL_PORT_RST && port_open_drain) else $error("port state");
    a_pullup_on: assert property (@(posedge clk)
        weak_pullup_en) else $error("pullups off");
    a_pin_drive: assert property (@(posedge clk) disable iff (rst)
        core_run |-> !rst_pin_oe) else $error("pin driven while running");
    a_pc_clear: assert property (@(posedge clk) disable iff (rst)
        $rose(core_run) |-> pc_value == RSTCTL_PC_RST && $past(pc_load)) else $error("pc");
    a_clk_internal: assert property (@(posedge clk) disable iff (rst)
        $rose(core_run) |-> clk_sel == RSTCTL_CLKSEL_INT) else $error("clock select");
    a_wdt_div: assert property (@(posedge clk) disable iff (rst)
        (wdt_tick && clk_en) ##1 (core_run && clk_en)[*8] |-> !wdt_tick)
        else $error("watchdog divide");
    a_start_stable: assert property (@(posedge clk) disable iff (rst)
        $rose(core_run) |-> $past(clk_s2)) else $error("start before clock stable");
    a_hold_release: assert property (@(posedge clk) disable iff (rst)
        sif.sync_rst |=> !core_run) else $error("release not synchronous");

    c_power_reset: cover property (@(posedge clk) disable iff (rst) $rose(rst_pin_oe));
    c_run_start: cover property (@(posedge clk) disable iff (rst) $rose(core_run));
    c_wdt_tick: cover property (@(posedge clk) disable iff (rst) wdt_tick);
    c_pin_reset: cover property (@(posedge clk) disable iff (rst) pin_s2 && !pwr_s2);
endmodule

// >>> tb/rstctl_far_model.sv
// Model of reset source detectors and the oscillator seen by the controller
`timescale 1ns/10ps
module rstctl_far_model
    import rstctl_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] src_cmd,
    input wire logic osc_cmd,
    output logic por_req,
    output logic vddmon_req,
    output logic pin_rst_n,
    output logic soft_req,
    output logic clk_stable
);
    ////////////////////////////////////////////////////////////////////////////
    // Quiet detectors and a stable oscillator at time zero
    initial begin
        por_req = 1'b0;
        vddmon_req = 1'b0;
        pin_rst_n = 1'b1;
        soft_req = 1'b0;
        clk_stable = 1'b1;
    end

    // Detectors follow the commanded levels one edge later
    always @(posedge clk) begin
        por_req <= src_cmd[RSTCTL_SRC_POR];
        vddmon_req <= src_cmd[RSTCTL_SRC_VDDMON];
        pin_rst_n <= !src_cmd[RSTCTL_SRC_PIN]; // Pin pulled low when asserted
        soft_req <= src_cmd[RSTCTL_SRC_SOFT];
        clk_stable <= osc_cmd; // Oscillator may settle late
    end
endmodule

// >>> tb/reset_state_controller_tb.sv
// Self-checking bench for the reset state controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module reset_state_controller_tb
    import rstctl_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, osc_cmd = 1'b1;
    logic [3:0] src_cmd = 4'h0; // Reset source commands to the model
    logic por_req, vddmon_req, pin_rst_n, soft_req, clk_stable;
    logic core_run, sfr_init, irq_disable, timer_disable, ram_keep, sp_init;
    logic port_open_drain, weak_pullup_en, rst_pin_out, rst_pin_oe, pc_load;
    logic wdt_enable, wdt_tick;
    logic [7:0] port_latch;
    logic [15:0] pc_value;
    logic [1:0] clk_sel;
    int n_mismatch = 0, compares = 0, cyc;

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 clk = ~clk;

    rstctl_top dut_u (.clk(clk), .rst(rst), .clk_en(clk_en), .por_req(por_req),
        .vddmon_req(vddmon_req), .pin_rst_n(pin_rst_n), .soft_req(soft_req),
        .clk_stable(clk_stable), .core_run(core_run), .sfr_init(sfr_init),
        .irq_disable(irq_disable), .timer_disable(timer_disable), .ram_keep(ram_keep),
        .sp_init(sp_init), .port_latch(port_latch), .port_open_drain(port_open_drain),
        .weak_pullup_en(weak_pullup_en), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .pc_value(pc_value), .pc_load(pc_load),
        .clk_sel(clk_sel), .wdt_enable(wdt_enable), .wdt_tick(wdt_tick));

    rstctl_far_model far_u (.clk(clk), .src_cmd(src_cmd), .osc_cmd(osc_cmd),
        .por_req(por_req), .vddmon_req(vddmon_req), .pin_rst_n(pin_rst_n),
        .soft_req(soft_req), .clk_stable(clk_stable));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Let n edges pass, then settle
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Count cycles until the core runs, bounded
    task automatic wait_run(input int bound);
        cyc = 0;
        while (core_run !== 1'b1) begin
            edges(1);
            cyc++;
            if (cyc > bound) begin
                n_mismatch++;
                wrap_up();
            end
        end
    endtask

    // Outputs while the reset state holds
    task automatic chk_halt();
        `CHK("core_run", 1'b0, core_run)
        `CHK("sfr_init", 1'b1, sfr_init)
        `CHK("irq_timer_off", 2'b11, {irq_disable, timer_disable})
        `CHK("ram_sp", 2'b11, {ram_keep, sp_init})
        `CHK("port_latch", 8'hff, port_latch)
        `CHK("open_drain", 1'b1, port_open_drain)
        `CHK("pullup_in", 1'b1, weak_pullup_en)
    endtask

    // Outputs once running again
    task automatic chk_run();
        `CHK("halt_outs", 3'h0, {sfr_init, irq_disable, timer_disable})
        `CHK("keep_outs", 3'h0, {ram_keep, sp_init, pc_load})
        `CHK("pullup_out", 1'b1, weak_pullup_en)
        `CHK("pc_value", 16'h0000, pc_value)
        `CHK("clk_sel", RSTCTL_CLKSEL_INT, clk_sel)
        `CHK("wdt_enable", 1'b1, wdt_enable)
        `CHK("pin_released", 1'b0, rst_pin_oe)
    endtask

    // One source asserted then released; pin drive expected or not
    task automatic sc_source(input int idx, input logic drive);
        @(posedge clk) src_cmd[idx] <= 1'b1;
        edges(8);
        chk_halt();
        `CHK("pin_oe", drive, rst_pin_oe)
        `CHK("pin_level", 1'b0, rst_pin_out)
        @(posedge clk) src_cmd[idx] <= 1'b0;
        wait_run(40);
        `CHK("sync_release", RSTCTL_HOLD_CYC + 5, cyc)
        chk_run();
    endtask

    // Late oscillator holds the core back
    task automatic sc_late_osc();
        @(posedge clk) begin
            osc_cmd <= 1'b0;
            src_cmd[RSTCTL_SRC_SOFT] <= 1'b1;
        end
        edges(4);
        @(posedge clk) src_cmd[RSTCTL_SRC_SOFT] <= 1'b0;
        edges(40);
        `CHK("wait_osc", 1'b0, core_run)
        `CHK("fetch_load", 1'b1, pc_load)
        @(posedge clk) osc_cmd <= 1'b1;
        wait_run(8);
        `CHK("osc_delay", 4, cyc)
        `CHK("first_fetch", 16'h0000, pc_value)
    endtask

    // Edges until the next watchdog tick, bounded
    task automatic count_tick(output int gap);
        gap = 0;
        do begin
            edges(1);
            gap++;
            if (gap > 30) begin
                n_mismatch++;
                wrap_up();
            end
        end while (wdt_tick !== 1'b1);
    endtask

    // Watchdog tick spacing, then spacing across a clock-enable pause
    task automatic sc_wdt();
        int gap;
        count_tick(gap);
        count_tick(gap);
        `CHK("wdt_gap", 12, gap)
        @(posedge clk) clk_en <= 1'b0;
        edges(3);
        @(posedge clk) clk_en <= 1'b1;
        count_tick(gap);
        `CHK("wdt_freeze", 11, gap)
    endtask

    // Power-on arriving while running stops the core quickly
    task automatic sc_midrun();
        @(posedge clk) src_cmd[RSTCTL_SRC_POR] <= 1'b1;
        edges(4);
        `CHK("fast_assert", 1'b0, core_run)
        @(posedge clk) src_cmd[RSTCTL_SRC_POR] <= 1'b0;
        wait_run(40);
        `CHK("midrun_release", RSTCTL_HOLD_CYC + 5, cyc)
        chk_run();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        edges(16);
        chk_halt();
        @(posedge clk) rst <= 1'b0;
        wait_run(40);
        chk_run();
        sc_source(RSTCTL_SRC_POR, 1'b1);
        sc_source(RSTCTL_SRC_VDDMON, 1'b1);
        sc_source(RSTCTL_SRC_PIN, 1'b0);
        sc_source(RSTCTL_SRC_SOFT, 1'b0);
        sc_late_osc();
        sc_wdt();
        sc_midrun();
        wrap_up();
    end
endmodule
